// ===== verilog/node_status_defs.vh
`ifndef NODE_STATUS_DEFS_VH
`define NODE_STATUS_DEFS_VH

// register offsets on the serial register map
`define ADDR_W 7
`define NODE_CFG_ADDR 7'h03
`define IO_STATUS_ADDR 7'h04

// serial_node_config fields
`define REPLY_DELAY_LSB 8
`define REPLY_DELAY_MSB 11
`define NODE_BASE_LSB 0
`define NODE_BASE_MSB 7
`define REPLY_DELAY_RST 4'h3
`define NODE_BASE_RST 8'h00

// input_and_status fields
`define VERSION_LSB 24
`define VERSION_MSB 31
`define FILTER_SEL_LSB 20
`define FILTER_SEL_MSB 21
`define DIE_REV_LSB 16
`define DIE_REV_MSB 18
`define QUIESCENT_BIT 15
`define NEXT_ADDR_BIT 13
`define REF_RES_BIT 12
`define EXTERNAL_CLOCK_FLAG_BIT 11
`define ADC_EN_BIT 9
`define TEMP_LSB 1
`define TEMP_MSB 8
`define FILTER_SEL_RST 2'h2
`define NEXT_ADDR_RST 1'b1
`define ADC_EN_RST 1'b1

// reply delay in bit times: base plus step per pair of codes
`define REPLY_BASE_BITS 7'h08
`define REPLY_STEP_BITS 7'h10

// input filter lengths, rounded up to whole clock cycles
`define CLK_PERIOD_NS 4
`define FILTER_SHORT_NS 10
`define FILTER_LONG_NS 20
`define FILTER_SHORT_CYC \
  ((`FILTER_SHORT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILTER_LONG_CYC \
  ((`FILTER_LONG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// address pin offset limits
`define PIN_OFFSET_MIN 3'h1
`define PIN_OFFSET_MAX 3'h6

`endif

// ===== verilog/pin_sync3.v
// three-stage pin synchroniser; output follows once stages two and three agree
module pin_sync3 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire [WIDTH-1:0] pin_i,
  output reg [WIDTH-1:0] level_o
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] mid_reg;
  reg [WIDTH-1:0] late_reg;
  integer k;

  // first stage feeds only the second stage
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      meta_reg <= RST_VAL;
      mid_reg <= RST_VAL;
      late_reg <= RST_VAL;
      level_o <= RST_VAL;
    end
    else
    begin
      meta_reg <= pin_i;
      mid_reg <= meta_reg;
      late_reg <= mid_reg;
      // per-bit agreement filters a single-cycle glitch
      for (k = 0; k < WIDTH; k = k + 1)
        if (mid_reg[k] == late_reg[k])
          level_o[k] <= late_reg[k];
    end
  end

endmodule // pin_sync3

// ===== verilog/reply_delay_timer.v
// counts bit-time ticks after a request ends and pulses when reply may start
module reply_delay_timer #(
  parameter CNT_W = 7
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire start_i,
  input wire tick_i,
  input wire [CNT_W-1:0] bit_times_i,
  output reg done_o
);

  reg [CNT_W-1:0] count_reg;
  reg busy_reg;

  // a new start restarts the wait; done is a one-cycle pulse
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      count_reg <= {CNT_W{1'b0}};
      busy_reg <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i)
      begin
        count_reg <= {CNT_W{1'b0}};
        busy_reg <= 1'b1;
      end
      else if (busy_reg && tick_i)
      begin
        if (count_reg == bit_times_i - {{(CNT_W-1){1'b0}}, 1'b1})
        begin
          busy_reg <= 1'b0;
          done_o <= 1'b1;
        end
        else
          count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // reply_delay_timer

// ===== verilog/node_status_regs.v
`include "node_status_defs.vh"

module node_status_regs #(
  // arbitrary neutral values, not tied to any part
  parameter [7:0] VERSION_CODE = 8'hA5,
  parameter [2:0] DIE_REVISION = 3'h2
) (
  input wire CLK_I,
  input wire RESET_N_I,
  // register access from the serial front end
  input wire [`ADDR_W-1:0] REG_ADDR_I,
  input wire [31:0] REG_WDATA_I,
  input wire REG_WR_I,
  input wire REG_RD_I,
  output reg [31:0] REG_RDATA_O,
  // pins and analog flags from outside the clock domain
  input wire [2:0] ADDR_SEL_PINS_I,
  input wire INTERFACE_SELECT_PIN_I,
  input wire REF_RESISTOR_DETECTED_I,
  input wire EXTERNAL_CLOCK_FLAG_I,
  // same-clock logic
  input wire QUIESCENT_I,
  input wire [7:0] TEMP_CODE_I,
  input wire SPI_SDO_I,
  input wire SPI_SDO_OE_I,
  input wire FRAME_ADDR_VALID_I,
  input wire [7:0] FRAME_ADDR_I,
  input wire READ_REQ_END_I,
  input wire BIT_TICK_I,
  // outputs
  output reg SDO_O,
  output reg SDO_OE_O,
  output reg SINGLE_WIRE_SERIAL_O,
  output reg [7:0] NODE_ADDR_O,
  output reg ADDR_MATCH_O,
  output reg REPLY_GO_O,
  output reg [1:0] FILTER_SEL_O,
  output reg [2:0] FILTER_CYCLES_O,
  output reg ADC_EN_O
);

  // filter lengths in whole cycles; three bits cover both settings
  localparam integer FILT_SHORT_INT = `FILTER_SHORT_CYC;
  localparam integer FILT_LONG_INT = `FILTER_LONG_CYC;
  localparam [2:0] FILT_SHORT = FILT_SHORT_INT[2:0];
  localparam [2:0] FILT_LONG = FILT_LONG_INT[2:0];

  // writable state
  reg [3:0] reply_delay_reg;
  reg [7:0] node_base_reg;
  reg [1:0] filter_sel_reg;
  reg next_addr_out_reg;
  reg adc_en_reg;

  // combinational helpers
  reg [2:0] pin_offset_next;
  reg [7:0] node_addr_next;
  reg [6:0] reply_bits_next;
  reg [2:0] filter_cycles_next;
  reg [31:0] node_cfg_word;
  reg [31:0] io_status_word;
  reg [31:0] rdata_next;
  reg sdo_next;
  reg sdo_oe_next;

  wire [2:0] addr_pins_sync;
  wire iface_sel_sync;
  wire ref_res_sync;
  wire external_clock_flag_sync;
  wire reply_done;

  // address pins are straps from outside; the interface select strap is synchronised with the flags below
  pin_sync3 #(
    .WIDTH(3),
    .RST_VAL(3'h0)
  ) u_addr_sync (
    .clk_i(CLK_I),
    .reset_n_i(RESET_N_I),
    .pin_i(ADDR_SEL_PINS_I),
    .level_o(addr_pins_sync)
  );

  // slow analog flags too; agreement of two stages hides chatter
  pin_sync3 #(
    .WIDTH(3),
    .RST_VAL(3'h0)
  ) u_flag_sync (
    .clk_i(CLK_I),
    .reset_n_i(RESET_N_I),
    .pin_i({INTERFACE_SELECT_PIN_I, REF_RESISTOR_DETECTED_I,
            EXTERNAL_CLOCK_FLAG_I}),
    .level_o({iface_sel_sync, ref_res_sync, external_clock_flag_sync})
  );

  // effective node address: base plus pin offset, clamped to one..six
  // pin values five to seven all fall back to the largest offset
  always @*
  begin
    if (addr_pins_sync >= `PIN_OFFSET_MAX - 3'h1)
      pin_offset_next = `PIN_OFFSET_MAX;
    else
      pin_offset_next = addr_pins_sync + `PIN_OFFSET_MIN;
    // wrap is the host's concern: base plus offset must stay below 256
    node_addr_next = node_base_reg + {5'h00, pin_offset_next};
  end

  // reply wait in bit times; each pair of codes shares one value
  always @*
  begin
    reply_bits_next = `REPLY_BASE_BITS
      + {reply_delay_reg[3:1], 4'h0};
  end

  // filter length; codes zero and one mean no filter
  always @*
  begin
    case (filter_sel_reg)
      2'h2: filter_cycles_next = FILT_SHORT;
      2'h3: filter_cycles_next = FILT_LONG;
      default: filter_cycles_next = 3'h0;
    endcase
  end

  // data-out pin: register level in UART mode, SPI engine otherwise
  // in uart mode the pin is always driven: it is the chain's address line
  always @*
  begin
    if (iface_sel_sync)
    begin
      sdo_next = next_addr_out_reg;
      sdo_oe_next = 1'b1;
    end
    else
    begin
      sdo_next = SPI_SDO_I;
      sdo_oe_next = SPI_SDO_OE_I;
    end
  end

  // node configuration read view; unused positions stay zero
  always @*
  begin
    node_cfg_word = 32'h00000000;
    node_cfg_word[`REPLY_DELAY_MSB:`REPLY_DELAY_LSB] = reply_delay_reg;
    node_cfg_word[`NODE_BASE_MSB:`NODE_BASE_LSB] = node_base_reg;
  end

  // input/status read view; live flags are taken at the read strobe
  always @*
  begin
    io_status_word = 32'h00000000;
    io_status_word[`VERSION_MSB:`VERSION_LSB] = VERSION_CODE;
    io_status_word[`FILTER_SEL_MSB:`FILTER_SEL_LSB] = filter_sel_reg;
    io_status_word[`DIE_REV_MSB:`DIE_REV_LSB] = DIE_REVISION;
    io_status_word[`QUIESCENT_BIT] = QUIESCENT_I;
    io_status_word[`NEXT_ADDR_BIT] = next_addr_out_reg;
    io_status_word[`REF_RES_BIT] = ref_res_sync;
    io_status_word[`EXTERNAL_CLOCK_FLAG_BIT] = external_clock_flag_sync;
    io_status_word[`ADC_EN_BIT] = adc_en_reg;
    io_status_word[`TEMP_MSB:`TEMP_LSB] = TEMP_CODE_I;
  end

  // read mux; unmapped offsets read zero
  // reads have no side effects, so a repeated read is harmless
  always @*
  begin
    if (REG_ADDR_I == `NODE_CFG_ADDR)
      rdata_next = node_cfg_word;
    else if (REG_ADDR_I == `IO_STATUS_ADDR)
      rdata_next = io_status_word;
    else
      rdata_next = 32'h00000000;
  end

  // node configuration writes; other offsets leave it alone
  always @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      reply_delay_reg <= `REPLY_DELAY_RST;
      node_base_reg <= `NODE_BASE_RST;
    end
    else if (REG_WR_I)
    begin
      if (REG_ADDR_I == `NODE_CFG_ADDR)
      begin
        reply_delay_reg <=
          REG_WDATA_I[`REPLY_DELAY_MSB:`REPLY_DELAY_LSB];
        node_base_reg <= REG_WDATA_I[`NODE_BASE_MSB:`NODE_BASE_LSB];
      end
    end
  end

  // io/status writes; read-only fields have no storage here
  always @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      filter_sel_reg <= `FILTER_SEL_RST;
      next_addr_out_reg <= `NEXT_ADDR_RST;
      adc_en_reg <= `ADC_EN_RST;
    end
    else if (REG_WR_I)
    begin
      if (REG_ADDR_I == `IO_STATUS_ADDR)
      begin
        // only the three writable fields take the data
        filter_sel_reg <=
          REG_WDATA_I[`FILTER_SEL_MSB:`FILTER_SEL_LSB];
        next_addr_out_reg <= REG_WDATA_I[`NEXT_ADDR_BIT];
        adc_en_reg <= REG_WDATA_I[`ADC_EN_BIT];
      end
    end
  end

  // read data holds until the next read strobe
  always @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      REG_RDATA_O <= 32'h00000000;
    else if (REG_RD_I)
      REG_RDATA_O <= rdata_next;
  end

  // wait the programmed bit times before a reply is sent
  // a repeated request restarts the wait instead of queueing a reply
  reply_delay_timer #(
    .CNT_W(7)
  ) u_reply_timer (
    .clk_i(CLK_I),
    .reset_n_i(RESET_N_I),
    .start_i(READ_REQ_END_I),
    .tick_i(BIT_TICK_I),
    .bit_times_i(reply_bits_next),
    .done_o(reply_done)
  );

  // pin drive outputs; enable stays low in reset so the pin floats
  always @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      SDO_O <= `NEXT_ADDR_RST;
      SDO_OE_O <= 1'b0;
      SINGLE_WIRE_SERIAL_O <= 1'b0;
    end
    else
    begin
      SDO_O <= sdo_next;
      SDO_OE_O <= sdo_oe_next;
      SINGLE_WIRE_SERIAL_O <= iface_sel_sync;
    end
  end

  // addressing and reply timing outputs
  always @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      NODE_ADDR_O <= 8'h00;
      ADDR_MATCH_O <= 1'b0;
      REPLY_GO_O <= 1'b0;
    end
    else
    begin
      NODE_ADDR_O <= node_addr_next;
      // only frames carrying our effective address are answered
      ADDR_MATCH_O <= FRAME_ADDR_VALID_I
        && (FRAME_ADDR_I == node_addr_next);
      // one more stage so the pulse leaves straight from a flip-flop
      REPLY_GO_O <= reply_done;
    end
  end

  // configuration outputs to the serial input filter and the adc
  always @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      FILTER_SEL_O <= `FILTER_SEL_RST;
      FILTER_CYCLES_O <= 3'h0;
      ADC_EN_O <= `ADC_EN_RST;
    end
    else
    begin
      FILTER_SEL_O <= filter_sel_reg;
      FILTER_CYCLES_O <= filter_cycles_next;
      ADC_EN_O <= adc_en_reg;
    end
  end

endmodule // node_status_regs

// ===== testbench/host_model.sv
// register-bus host: strobes launched on the falling edge, one word at a time
module host_model (
  input wire CLK_I,
  input wire [31:0] REG_RDATA_O,
  output logic [6:0] REG_ADDR_I = 7'h00,
  output logic [31:0] REG_WDATA_I = 32'h00000000,
  output logic REG_WR_I = 1'b0,
  output logic REG_RD_I = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // one node on the line, so the short reply delay codes are legal
  // callers keep base plus pin offset below 255
  task wr_reg(input logic [6:0] a, input logic [31:0] d);
    @(negedge CLK_I);
    REG_ADDR_I = a;
    REG_WDATA_I = d;
    REG_WR_I = 1'b1;
    @(negedge CLK_I);
    REG_WR_I = 1'b0;
    REG_WDATA_I = ~d; // released data must not look valid
  endtask
  // read data lands on the rising edge that samples the strobe; taken at the next falling edge
  task rd_reg(input logic [6:0] a, output logic [31:0] d);
    @(negedge CLK_I);
    REG_ADDR_I = a;
    REG_RD_I = 1'b1;
    @(negedge CLK_I);
    REG_RD_I = 1'b0;
    d = REG_RDATA_O;
  endtask
endmodule // host_model

// ===== testbench/node_status_regs_sva.sv
module node_status_regs_sva #(
  parameter [7:0] VERSION_CODE = 8'hA5
) (
  input wire CLK_I, input wire RESET_N_I,
  input wire [6:0] REG_ADDR_I, input wire [31:0] REG_WDATA_I,
  input wire REG_WR_I, input wire REG_RD_I, input wire [31:0] REG_RDATA_O,
  input wire QUIESCENT_I, input wire [7:0] TEMP_CODE_I,
  input wire SPI_SDO_I, input wire SPI_SDO_OE_I,
  input wire FRAME_ADDR_VALID_I, input wire [7:0] FRAME_ADDR_I,
  input wire READ_REQ_END_I, input wire BIT_TICK_I,
  input wire SDO_O, input wire SDO_OE_O, input wire SINGLE_WIRE_SERIAL_O,
  input wire [7:0] NODE_ADDR_O, input wire ADDR_MATCH_O,
  input wire REPLY_GO_O, input wire [1:0] FILTER_SEL_O,
  input wire [2:0] FILTER_CYCLES_O, input wire ADC_EN_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  reg [3:0] code_reg;
  reg [6:0] cnt_reg;
  reg armed_reg;
  wire [6:0] n_bits = 7'h08 + {code_reg[3:1], 4'h0};
  wire hit = armed_reg && BIT_TICK_I && cnt_reg == n_bits - 7'h01;
  // shadow of the delay code and tick count; a new start restarts it
  always @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      code_reg <= 4'h3;
      cnt_reg <= 7'h00;
      armed_reg <= 1'b0;
    end
    else
    begin
      if (REG_WR_I && REG_ADDR_I == 7'h03)
        code_reg <= REG_WDATA_I[11:8];
      if (READ_REQ_END_I)
      begin
        cnt_reg <= 7'h00;
        armed_reg <= 1'b1;
      end
      else if (hit)
        armed_reg <= 1'b0;
      else if (armed_reg && BIT_TICK_I)
        cnt_reg <= cnt_reg + 7'h01;
    end
  end
  sequence s_wr_io;
    REG_WR_I && REG_ADDR_I == 7'h04 ##1 !REG_WR_I;
  endsequence
  sequence s_rd_io;
    REG_RD_I && REG_ADDR_I == 7'h04;
  endsequence
  property p_reply; hit |-> ##[1:2] REPLY_GO_O; endproperty
  a_reply: assert property (p_reply) else $error("reply late");
  property p_match; FRAME_ADDR_VALID_I && FRAME_ADDR_I == NODE_ADDR_O
    && $stable(NODE_ADDR_O) |=> ADDR_MATCH_O; endproperty
  a_match: assert property (p_match) else $error("no match");
  property p_nomatch; FRAME_ADDR_VALID_I && FRAME_ADDR_I != NODE_ADDR_O
    && $stable(NODE_ADDR_O) |=> !ADDR_MATCH_O; endproperty
  a_nomatch: assert property (p_nomatch) else $error("bad match");
  property p_uart; SINGLE_WIRE_SERIAL_O [*2] |-> SDO_OE_O; endproperty
  a_uart: assert property (p_uart) else $error("sdo idle");
  property p_spi; (!SINGLE_WIRE_SERIAL_O) [*2] |-> SDO_O == $past(SPI_SDO_I)
    && SDO_OE_O == $past(SPI_SDO_OE_I); endproperty
  a_spi: assert property (p_spi) else $error("sdo pass");
  property p_filter; ($stable(FILTER_SEL_O)) [*3] |-> FILTER_CYCLES_O ==
    (FILTER_SEL_O == 2'h3 ? 3'h5 : FILTER_SEL_O == 2'h2 ? 3'h3 : 3'h0);
  endproperty
  a_filter: assert property (p_filter) else $error("filter len");
  property p_adc; s_wr_io |-> ##1 ADC_EN_O == $past(REG_WDATA_I[9], 2)
    && FILTER_SEL_O == $past(REG_WDATA_I[21:20], 2); endproperty
  a_adc: assert property (p_adc) else $error("io write");
  property p_io_read; s_rd_io |=> REG_RDATA_O[31:24] == VERSION_CODE
    && REG_RDATA_O[15] == $past(QUIESCENT_I)
    && REG_RDATA_O[8:1] == $past(TEMP_CODE_I); endproperty
  a_io_read: assert property (p_io_read)
    else $error("io read");
  property p_reserved; s_rd_io |=> (REG_RDATA_O & 32'h00C84401) == 0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved");
  property p_unmapped; REG_RD_I && REG_ADDR_I != 7'h03
    && REG_ADDR_I != 7'h04 |=> REG_RDATA_O == 32'h00000000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped");
endmodule // node_status_regs_sva
bind node_status_regs node_status_regs_sva #(.VERSION_CODE(VERSION_CODE))
  node_status_regs_sva_inst (.*);

// ===== testbench/node_config_io_status_regs_tb.sv
module node_config_io_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_I = 1'b0, RESET_N_I = 1'b0, QUIESCENT_I = 1'b0;
  logic [2:0] ADDR_SEL_PINS_I = 3'h0;
  logic INTERFACE_SELECT_PIN_I = 1'b0, REF_RESISTOR_DETECTED_I = 1'b0;
  logic EXTERNAL_CLOCK_FLAG_I = 1'b0, SPI_SDO_I = 1'b0, SPI_SDO_OE_I = 1'b0;
  logic FRAME_ADDR_VALID_I = 1'b0, READ_REQ_END_I = 1'b0, BIT_TICK_I = 1'b0;
  logic [7:0] TEMP_CODE_I = 8'h00, FRAME_ADDR_I = 8'h00;
  wire [6:0] REG_ADDR_I;
  wire [31:0] REG_WDATA_I, REG_RDATA_O;
  wire REG_WR_I, REG_RD_I, SDO_O, SDO_OE_O, SINGLE_WIRE_SERIAL_O;
  wire ADDR_MATCH_O, REPLY_GO_O, ADC_EN_O;
  wire [7:0] NODE_ADDR_O;
  wire [1:0] FILTER_SEL_O;
  wire [2:0] FILTER_CYCLES_O;
  int num_errors = 0, n_checks = 0, cyc = 0;
  logic [31:0] rd;
  localparam [31:0] FIX = 32'hA5020000; // default version and revision
  node_status_regs node_status_regs_inst (.*);
  host_model host_model_inst (.*);
  always #2 CLK_I = ~CLK_I;
  // hang guard, well past the few hundred cycles the tests need
  always @(posedge CLK_I)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      num_errors++;
      final_report();
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task t_reset;
    host_model_inst.rd_reg(7'h03, rd);
    chk("node_cfg", 32'h00000300, rd);
    host_model_inst.rd_reg(7'h04, rd);
    chk("io_rst", FIX | 32'h00202200, rd);
  endtask
  task t_flags;
    QUIESCENT_I = 1'b1;
    TEMP_CODE_I = 8'hC3;
    REF_RESISTOR_DETECTED_I = 1'b1;
    EXTERNAL_CLOCK_FLAG_I = 1'b1;
    repeat (6) @(negedge CLK_I);
    host_model_inst.rd_reg(7'h04, rd);
    chk("io_flags", FIX | 32'h0020BB86, rd);
    {QUIESCENT_I, REF_RESISTOR_DETECTED_I, EXTERNAL_CLOCK_FLAG_I} = 3'h0;
    TEMP_CODE_I = 8'h00;
    repeat (6) @(negedge CLK_I); // cleared flags pass the synchroniser
  endtask
  task t_rw_io;
    host_model_inst.wr_reg(7'h04, 32'hFFFFFFFF);
    host_model_inst.rd_reg(7'h04, rd);
    chk("io_ro", FIX | 32'h00302200, rd);
    for (int i = 0; i < 4; i++)
    begin
      host_model_inst.wr_reg(7'h04, i << 20);
      host_model_inst.rd_reg(7'h04, rd);
      chk("flt_sel", i, FILTER_SEL_O);
      chk("flt_cyc", i == 3 ? 5 : i == 2 ? 3 : 0, FILTER_CYCLES_O);
      chk("adc_off", 0, ADC_EN_O);
    end
    host_model_inst.wr_reg(7'h05, 32'hFFFFFFFF);
    host_model_inst.rd_reg(7'h05, rd);
    chk("unmapped", 0, rd);
    host_model_inst.wr_reg(7'h04, 32'h00202200);
    host_model_inst.rd_reg(7'h04, rd);
    chk("adc_on", 1, ADC_EN_O);
  endtask
  task t_addr;
    logic [7:0] ea;
    host_model_inst.wr_reg(7'h03, 32'h00000310);
    for (int v = 0; v < 8; v++)
    begin
      ADDR_SEL_PINS_I = v;
      repeat (6) @(negedge CLK_I);
      ea = 8'h10 + (v > 4 ? 6 : v + 1);
      chk("node_addr", ea, NODE_ADDR_O);
      FRAME_ADDR_I = ea;
      FRAME_ADDR_VALID_I = 1'b1;
      @(negedge CLK_I);
      chk("match", 1, ADDR_MATCH_O);
      FRAME_ADDR_I = ea + 8'h01;
      @(negedge CLK_I);
      FRAME_ADDR_VALID_I = 1'b0;
      chk("nomatch", 0, ADDR_MATCH_O);
    end
  endtask
  task t_sdo;
    INTERFACE_SELECT_PIN_I = 1'b1;
    repeat (6) @(negedge CLK_I);
    chk("uart_sel", 1, SINGLE_WIRE_SERIAL_O);
    chk("nao_high", 2'b11, {SDO_OE_O, SDO_O});
    host_model_inst.wr_reg(7'h04, 32'h00200200);
    repeat (2) @(negedge CLK_I);
    chk("nao_low", 2'b10, {SDO_OE_O, SDO_O});
    INTERFACE_SELECT_PIN_I = 1'b0;
    {SPI_SDO_OE_I, SPI_SDO_I} = 2'b11;
    repeat (6) @(negedge CLK_I);
    chk("spi_hi", 2'b11, {SDO_OE_O, SDO_O});
    SPI_SDO_I = 1'b0;
    @(negedge CLK_I);
    chk("spi_lo", 2'b10, {SDO_OE_O, SDO_O});
  endtask
  // start, then a tick every cycle; the pulse lands one edge after tick N
  task t_reply;
    logic [3:0] c;
    int k;
    for (int i = 0; i < 3; i++)
    begin
      c = i == 0 ? 4'h0 : i == 1 ? 4'h3 : 4'hF;
      host_model_inst.wr_reg(7'h03, {20'h0, c, 8'h10});
      READ_REQ_END_I = 1'b1;
      @(negedge CLK_I);
      READ_REQ_END_I = 1'b0;
      BIT_TICK_I = 1'b1;
      k = 0;
      while (REPLY_GO_O !== 1'b1 && k < 300)
      begin
        @(negedge CLK_I);
        k++;
      end
      BIT_TICK_I = 1'b0;
      chk("reply_wait", 8 + 16 * (c >> 1) + 1, k);
    end
  endtask
  initial
  begin
    repeat (20) @(negedge CLK_I);
    RESET_N_I = 1'b1;
    t_reset();
    t_flags();
    t_rw_io();
    t_addr();
    t_sdo();
    t_reply();
    final_report();
  end
endmodule // node_config_io_status_regs_tb
